/* File: include/pblc_pkg.sv */
// Package for the push-button and output-switch controller.
// Assumes a single 100 MHz clock and an APB register port with 32-bit data.
package pblc_pkg;

    // Clock rate used to turn times into cycle counts.
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned CLK_KHZ       = 1_000_000 / CLK_PERIOD_NS;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_BTN   = 8'h04;
    localparam logic [7:0] OFS_IRQ   = 8'h08;
    localparam logic [7:0] OFS_MASK  = 8'h0C;
    localparam logic [7:0] OFS_STATE = 8'h10;

    // Control register fields.
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_CODE_LSB  = 1;
    localparam int CODE_W         = 5;
    localparam int CTRL_RAIL_BIT  = 6;
    localparam logic [CODE_W-1:0] CODE_RST = 5'h0A;

    // Push-button register fields.
    localparam int BTN_WAKE_LSB = 0;
    localparam int BTN_HOLD_LSB = 2;
    localparam int BTN_REC_BIT  = 4;
    localparam int BTN_NEED_BIT = 5;
    localparam int BTN_WF1_BIT  = 8;
    localparam int BTN_WF2_BIT  = 9;
    localparam int BTN_RFLT_BIT = 10;

    // Interrupt status and mask bits.
    localparam int IRQ_W        = 2;
    localparam int IRQ_WAKE_BIT = 0;
    localparam int IRQ_RST_BIT  = 1;

    // Output voltage: base plus code times step, and pass-through limit.
    localparam logic [11:0] VOUT_BASE_MV = 12'h320;
    localparam logic [11:0] VOUT_STEP_MV = 12'h064;
    localparam logic [11:0] VOUT_PASS_MV = 12'hCE4;

    // Hold and pulse times in their own units, and derived cycle counts.
    localparam int unsigned WAKE_MS [4] = '{50, 100, 500, 1000};
    localparam int unsigned HOLD_MS [4] = '{4000, 8000, 12000, 16000};
    localparam int unsigned RESET_D_MS   = 400;
    localparam int unsigned INT_PULSE_NS = 128_000;
    localparam int unsigned WAKE_CYC [4] = '{WAKE_MS[0] * CLK_KHZ,
        WAKE_MS[1] * CLK_KHZ, WAKE_MS[2] * CLK_KHZ, WAKE_MS[3] * CLK_KHZ};
    localparam int unsigned HOLD_CYC [4] = '{HOLD_MS[0] * CLK_KHZ,
        HOLD_MS[1] * CLK_KHZ, HOLD_MS[2] * CLK_KHZ, HOLD_MS[3] * CLK_KHZ};
    localparam int unsigned RESET_D_CYC = RESET_D_MS * CLK_KHZ;
    localparam int unsigned INT_CYC =
        (INT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Pins arriving from outside the clock domain.
    typedef struct packed {
        logic push_button_n;
        logic output_switch_pin;
        logic battery_present;
        logic input_valid;
        logic charge_enable;
        logic switch_fault;
    } pblc_pins_t;
    localparam pblc_pins_t PINS_RST = 6'h20;

    // Button sequencer states.
    typedef enum logic [1:0] {
        BTN_IDLE  = 2'b00,
        BTN_PRESS = 2'b01,
        BTN_WAKE  = 2'b10,
        BTN_HELD  = 2'b11
    } pblc_btn_t;

endpackage

/* File: design/pblc_top.sv */
// Push-button reset sequencer and output-switch control with an APB port.
// Assumes pins are asynchronous to CLK_IN and are synchronised here.
//
// Contract
// - Output pulled down when register enable and pin are both low.
// - Target voltage is 0.8 V plus code times 100 mV.
// - Code above 3.3 V makes the enabled output a pass-through switch.
// - Pin is active high and keeps the switch on unless faulted or in ship mode.
// - Disabled output always turns on the internal pulldown.
// - Button honoured only with battery, or valid input and charging.
// - Wake and reset hold times come from separate select fields.
// - Wake met gives a 128 us interrupt pulse and sets wake flags.
// - Wake and reset flags stay set until button register read.
// - Reset hold met gives a 128 us interrupt pulse and reset low.
// - One reset pulse of set duration per hold, no repeat while held.
// - New reset needs release, then a new press for the hold time.
// - Battery-only reset enters ship or high-impedance per recovery field.
// - Reset with valid input keeps the prior operating state.
// - Disabled system rail comes back when recovering to active modes.
// - A bit selects whether reset also needs a valid input supply.
// - Disabled rail returns only on input connect or reset hold.
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ns

module pblc_top
    import pblc_pkg::*;
#(
    parameter int unsigned WAKE_CYC_P [4] = pblc_pkg::WAKE_CYC,
    parameter int unsigned HOLD_CYC_P [4] = pblc_pkg::HOLD_CYC,
    parameter int unsigned RESET_D_P      = pblc_pkg::RESET_D_CYC,
    parameter int unsigned INT_CYC_P      = pblc_pkg::INT_CYC
) (
    input  wire logic                      CLK_IN,
    input  wire logic                      NRST_IN,
    input  wire pblc_pkg::pblc_pins_t      PINS_IN,
    input  wire logic                      PSEL_IN,
    input  wire logic                      PENABLE_IN,
    input  wire logic                      PWRITE_IN,
    input  wire logic [7:0]                PADDR_IN,
    input  wire logic [31:0]               PWDATA_IN,
    output logic [31:0]                    PRDATA_OUT,
    output logic                           PREADY_OUT,
    output logic                           PSLVERR_OUT,
    output logic                           SWITCH_ENABLE_OUT,
    output logic                           PASS_THROUGH_OUT,
    output logic                           PULLDOWN_OUT,
    output logic [11:0]                    TARGET_MV_OUT,
    output logic                           HOST_INT_N_OUT,
    output logic                           IRQ_OUT,
    output logic                           RESET_N_OUT,
    output logic                           SYSTEM_RAIL_EN_OUT,
    output logic                           SHIP_MODE_OUT,
    output logic                           HIZ_MODE_OUT
);
    import pblc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    pblc_pins_t meta_q;
    pblc_pins_t pins_q;

    // Two flops per pin; the first stage feeds only the second.
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_sync
            always_ff @(posedge CLK_IN) begin
                if (!NRST_IN) begin
                    meta_q[gi] <= PINS_RST[gi];
                    pins_q[gi] <= PINS_RST[gi];
                end else begin
                    meta_q[gi] <= PINS_IN[gi];
                    pins_q[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, answer in the second access cycle.

    logic                     ready_q;
    logic [31:0]              rdata_q;
    logic                     slverr_q;
    logic                     reg_en_q;
    logic [CODE_W-1:0]        code_q;
    logic [1:0]               wake_sel_q;
    logic [1:0]               hold_sel_q;
    logic                     rec_hiz_q;
    logic                     need_in_q;
    logic                     wf1_q;
    logic                     wf2_q;
    logic                     rflt_q;
    logic [IRQ_W-1:0]         irq_q;
    logic [IRQ_W-1:0]         mask_q;

    wire access    = PSEL_IN & PENABLE_IN;
    wire done      = access & ready_q;
    wire wr_done   = done & PWRITE_IN;
    wire rd_done   = done & ~PWRITE_IN;
    wire hit_ctrl  = PADDR_IN == OFS_CTRL;
    wire hit_btn   = PADDR_IN == OFS_BTN;
    wire hit_irq   = PADDR_IN == OFS_IRQ;
    wire hit_mask  = PADDR_IN == OFS_MASK;
    wire hit_state = PADDR_IN == OFS_STATE;
    wire mapped    = hit_ctrl | hit_btn | hit_irq | hit_mask | hit_state;
    wire wr_ctrl   = wr_done & hit_ctrl;
    wire wr_btn    = wr_done & hit_btn;
    wire wr_irq    = wr_done & hit_irq;
    wire wr_mask   = wr_done & hit_mask;
    wire rd_btn    = rd_done & hit_btn;

    ////////////////////////////////////////////////////////////////////////
    // Output switch decode.

    logic [11:0] target_mv;
    logic        ship_q;
    logic        sw_en;

    // Fault or ship mode overrides both enable sources.
    assign sw_en = (reg_en_q | pins_q.output_switch_pin)
                 & ~pins_q.switch_fault & ~ship_q;
    assign target_mv = VOUT_BASE_MV
                     + 12'(code_q) * VOUT_STEP_MV;
    wire   pass_mode = target_mv > VOUT_PASS_MV;

    ////////////////////////////////////////////////////////////////////////
    // Button sequencer.

    pblc_btn_t   btn_q;
    pblc_btn_t   btn_d;
    logic [31:0] hold_cnt_q;
    logic [31:0] hold_cnt_d;
    logic        wake_evt;
    logic        rst_evt;

    // Button is ignored unless battery or charging input is there.
    wire honour  = pins_q.battery_present
                 | (pins_q.input_valid & pins_q.charge_enable);
    wire pressed = honour & ~pins_q.push_button_n;
    wire [31:0] wake_lim = WAKE_CYC_P[wake_sel_q];
    wire [31:0] hold_lim = HOLD_CYC_P[hold_sel_q];
    wire [31:0] cnt_inc  = hold_cnt_q + 32'h0000_0001;
    wire rst_allow = ~need_in_q | pins_q.input_valid;

    // Holding a press after reset parks in HELD until release.
    always_comb begin
        btn_d      = btn_q;
        hold_cnt_d = hold_cnt_q;
        wake_evt   = 1'b0;
        rst_evt    = 1'b0;
        unique case (btn_q)
            BTN_IDLE: begin
                hold_cnt_d = 32'h0000_0000;
                if (pressed) begin
                    btn_d = BTN_PRESS;
                end
            end
            BTN_PRESS: begin
                hold_cnt_d = cnt_inc;
                if (!pressed) begin
                    btn_d = BTN_IDLE;
                end else if (cnt_inc >= wake_lim) begin
                    btn_d    = BTN_WAKE;
                    wake_evt = 1'b1;
                end
            end
            BTN_WAKE: begin
                hold_cnt_d = cnt_inc;
                if (!pressed) begin
                    btn_d = BTN_IDLE;
                end else if (cnt_inc >= hold_lim && rst_allow) begin
                    btn_d   = BTN_HELD;
                    rst_evt = 1'b1;
                end
            end
            BTN_HELD: begin
                if (pins_q.push_button_n) begin
                    btn_d = BTN_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            btn_q      <= BTN_IDLE;
            hold_cnt_q <= 32'h0000_0000;
        end else begin
            btn_q      <= btn_d;
            hold_cnt_q <= hold_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt pulse and reset pulse timers.

    logic [31:0] int_cnt_q;
    logic [31:0] rst_cnt_q;

    // A new event restarts the pulse rather than stretching it.
    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            int_cnt_q <= 32'h0000_0000;
            rst_cnt_q <= 32'h0000_0000;
        end else begin
            if (wake_evt || rst_evt) begin
                int_cnt_q <= INT_CYC_P;
            end else if (int_cnt_q != 32'h0000_0000) begin
                int_cnt_q <= int_cnt_q - 32'h0000_0001;
            end
            if (rst_evt) begin
                rst_cnt_q <= RESET_D_P;
            end else if (rst_cnt_q != 32'h0000_0000) begin
                rst_cnt_q <= rst_cnt_q - 32'h0000_0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Recovery and system rail.

    logic rail_q;
    logic hiz_q;
    logic vin_prev_q;

    wire vin_rise = pins_q.input_valid & ~vin_prev_q;
    wire bat_only = ~pins_q.input_valid;

    // With input present ship clears and the rail turns back on; the hiz state is kept.
    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            rail_q     <= 1'b1;
            ship_q     <= 1'b0;
            hiz_q      <= 1'b0;
            vin_prev_q <= 1'b0;
        end else begin
            vin_prev_q <= pins_q.input_valid;
            if (rst_evt && bat_only) begin
                ship_q <= ~rec_hiz_q;
                hiz_q  <= rec_hiz_q;
                rail_q <= rec_hiz_q;
            end else if (rst_evt || vin_rise) begin
                ship_q <= 1'b0;
                rail_q <= 1'b1;
            end else if (wr_ctrl && !PWDATA_IN[CTRL_RAIL_BIT]) begin
                rail_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers.

    // Hardware set wins over a clearing read or write in the same cycle.
    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            reg_en_q   <= 1'b0;
            code_q     <= CODE_RST;
            wake_sel_q <= 2'h0;
            hold_sel_q <= 2'h0;
            rec_hiz_q  <= 1'b0;
            need_in_q  <= 1'b0;
            wf1_q      <= 1'b0;
            wf2_q      <= 1'b0;
            rflt_q     <= 1'b0;
            irq_q      <= '0;
            mask_q     <= '0;
        end else begin
            if (wr_ctrl) begin
                reg_en_q <= PWDATA_IN[CTRL_EN_BIT];
                code_q   <= PWDATA_IN[CTRL_CODE_LSB +: CODE_W];
            end
            if (wr_btn) begin
                wake_sel_q <= PWDATA_IN[BTN_WAKE_LSB +: 2];
                hold_sel_q <= PWDATA_IN[BTN_HOLD_LSB +: 2];
                rec_hiz_q  <= PWDATA_IN[BTN_REC_BIT];
                need_in_q  <= PWDATA_IN[BTN_NEED_BIT];
            end
            wf1_q  <= wake_evt | (wf1_q & ~rd_btn);
            wf2_q  <= (wake_evt & wf1_q) | (wf2_q & ~rd_btn);
            rflt_q <= rst_evt | (rflt_q & ~rd_btn);
            irq_q  <= {rst_evt, wake_evt}
                    | (irq_q & ~({IRQ_W{wr_irq}} & PWDATA_IN[IRQ_W-1:0]));
            if (wr_mask) begin
                mask_q <= PWDATA_IN[IRQ_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data multiplexer.

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_mux[CTRL_EN_BIT]               = reg_en_q;
            rd_mux[CTRL_CODE_LSB +: CODE_W]   = code_q;
            rd_mux[CTRL_RAIL_BIT]             = rail_q;
        end else if (hit_btn) begin
            rd_mux[BTN_WAKE_LSB +: 2] = wake_sel_q;
            rd_mux[BTN_HOLD_LSB +: 2] = hold_sel_q;
            rd_mux[BTN_REC_BIT]       = rec_hiz_q;
            rd_mux[BTN_NEED_BIT]      = need_in_q;
            rd_mux[BTN_WF1_BIT]       = wf1_q;
            rd_mux[BTN_WF2_BIT]       = wf2_q;
            rd_mux[BTN_RFLT_BIT]      = rflt_q;
        end else if (hit_irq) begin
            rd_mux[IRQ_W-1:0] = irq_q;
        end else if (hit_mask) begin
            rd_mux[IRQ_W-1:0] = mask_q;
        end else if (hit_state) begin
            rd_mux[8:0] = {rst_cnt_q != 32'h0000_0000, btn_q, hiz_q,
                           ship_q, rail_q, ~sw_en, sw_en & pass_mode,
                           sw_en};
        end
    end

    // Data and error are captured as ready rises and held with it.
    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            ready_q  <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else begin
            ready_q <= access & ~ready_q;
            if (access && !ready_q) begin
                rdata_q  <= PWRITE_IN ? 32'h0000_0000 : rd_mux;
                slverr_q <= ~mapped;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output flops.

    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            SWITCH_ENABLE_OUT  <= 1'b0;
            PASS_THROUGH_OUT   <= 1'b0;
            PULLDOWN_OUT       <= 1'b1;
            TARGET_MV_OUT      <= 12'h000;
            HOST_INT_N_OUT     <= 1'b1;
            IRQ_OUT            <= 1'b0;
            RESET_N_OUT        <= 1'b1;
            SYSTEM_RAIL_EN_OUT <= 1'b1;
            SHIP_MODE_OUT      <= 1'b0;
            HIZ_MODE_OUT       <= 1'b0;
        end else begin
            SWITCH_ENABLE_OUT  <= sw_en;
            PASS_THROUGH_OUT   <= sw_en & pass_mode;
            PULLDOWN_OUT       <= ~sw_en;
            TARGET_MV_OUT      <= target_mv;
            HOST_INT_N_OUT     <= int_cnt_q == 32'h0000_0000;
            IRQ_OUT            <= |(irq_q & mask_q);
            RESET_N_OUT        <= rst_cnt_q == 32'h0000_0000;
            SYSTEM_RAIL_EN_OUT <= rail_q;
            SHIP_MODE_OUT      <= ship_q;
            HIZ_MODE_OUT       <= hiz_q;
        end
    end

    assign PRDATA_OUT  = rdata_q;
    assign PREADY_OUT  = ready_q;
    assign PSLVERR_OUT = slverr_q;

endmodule

/* File: verification/pblc_checker.sv */
// Checker for the push-button and output-switch controller.
// Assumes it is bound to pblc_top and sees only that module's ports.
`timescale 1ns/1ns
module pblc_checker
    import pblc_pkg::*;
#(
    parameter int unsigned RESET_D_P = 40,
    parameter int unsigned INT_CYC_P = 16
) (
    input wire logic                 CLK_IN,
    input wire logic                 NRST_IN,
    input wire pblc_pkg::pblc_pins_t PINS_IN,
    input wire logic                 PSEL_IN,
    input wire logic                 PENABLE_IN,
    input wire logic                 PREADY_OUT,
    input wire logic                 SWITCH_ENABLE_OUT,
    input wire logic                 PASS_THROUGH_OUT,
    input wire logic                 PULLDOWN_OUT,
    input wire logic [11:0]          TARGET_MV_OUT,
    input wire logic                 HOST_INT_N_OUT,
    input wire logic                 RESET_N_OUT,
    input wire logic                 SYSTEM_RAIL_EN_OUT,
    input wire logic                 SHIP_MODE_OUT,
    input wire logic                 HIZ_MODE_OUT
);
    logic [15:0] int_cnt_q, rst_cnt_q;
    logic        rel_q;

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);

    ////////////////////////////////////////////////////////////////////////
    // Pulses outlast a repetition, so low cycles are counted.
    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            int_cnt_q <= 16'h0;
            rst_cnt_q <= 16'h0;
            rel_q     <= 1'b1;
        end else begin
            int_cnt_q <= HOST_INT_N_OUT ? 16'h0 : int_cnt_q + 16'h1;
            rst_cnt_q <= RESET_N_OUT ? 16'h0 : rst_cnt_q + 16'h1;
            rel_q     <= PINS_IN.push_button_n | (rel_q & ~$fell(RESET_N_OUT));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output switch relations.
    property p_pulldown;
        PULLDOWN_OUT == !SWITCH_ENABLE_OUT;
    endproperty
    a_pulldown: assert property (p_pulldown)
        else $error("pulldown wrong");
    property p_pass;
        PASS_THROUGH_OUT == (SWITCH_ENABLE_OUT && TARGET_MV_OUT > VOUT_PASS_MV);
    endproperty
    a_pass: assert property (p_pass)
        else $error("pass-through wrong");
    property p_target;
        TARGET_MV_OUT != 12'h000 |->
            (TARGET_MV_OUT - VOUT_BASE_MV) % VOUT_STEP_MV == 12'h000;
    endproperty
    a_target: assert property (p_target)
        else $error("target off grid");
    property p_switch;
        (PINS_IN.output_switch_pin && !PINS_IN.switch_fault
            && !SHIP_MODE_OUT)[*3] |=> SWITCH_ENABLE_OUT;
    endproperty
    a_switch: assert property (p_switch)
        else $error("switch off with pin high");
    property p_fault;
        PINS_IN.switch_fault[*3] |=> !SWITCH_ENABLE_OUT;
    endproperty
    a_fault: assert property (p_fault)
        else $error("switch on in fault");

    ////////////////////////////////////////////////////////////////////////
    // Push-button pulses, recovery and bus answer.
    property p_int_len;
        $rose(HOST_INT_N_OUT) |-> int_cnt_q == INT_CYC_P;
    endproperty
    a_int_len: assert property (p_int_len)
        else $error("bad interrupt width");
    property p_rst_len;
        $rose(RESET_N_OUT) |-> rst_cnt_q == RESET_D_P;
    endproperty
    a_rst_len: assert property (p_rst_len)
        else $error("bad reset width");
    property p_rst_int;
        $fell(RESET_N_OUT) |-> ##[0:2] !HOST_INT_N_OUT;
    endproperty
    a_rst_int: assert property (p_rst_int)
        else $error("reset without interrupt");
    property p_once;
        $fell(RESET_N_OUT) |-> rel_q;
    endproperty
    a_once: assert property (p_once)
        else $error("reset repeated unreleased");
    property p_ship;
        $rose(SHIP_MODE_OUT) |-> ##[0:3]
            (!SYSTEM_RAIL_EN_OUT && !SWITCH_ENABLE_OUT && !HIZ_MODE_OUT);
    endproperty
    a_ship: assert property (p_ship)
        else $error("ship mode left rail on");
    property p_apb;
        PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT;
    endproperty
    a_apb: assert property (p_apb)
        else $error("bus not answered in time");
endmodule

bind pblc_top pblc_checker #(.RESET_D_P(RESET_D_P), .INT_CYC_P(INT_CYC_P))
    i_chk (.CLK_IN, .NRST_IN, .PINS_IN, .PSEL_IN, .PENABLE_IN, .PREADY_OUT,
    .SWITCH_ENABLE_OUT, .PULLDOWN_OUT, .PASS_THROUGH_OUT, .TARGET_MV_OUT,
    .HOST_INT_N_OUT, .RESET_N_OUT, .SYSTEM_RAIL_EN_OUT, .SHIP_MODE_OUT,
    .HIZ_MODE_OUT);

/* File: verification/pblc_host.sv */
// Host-side model: drives supply, switch and button pins, counts pulses.
// Assumes its tasks are called from one bench process only.
`timescale 1ns/1ns
module pblc_host
    import pblc_pkg::*;
(
    input  wire logic            clk_in,
    input  wire logic            host_int_n_in,
    input  wire logic            reset_n_in,
    output pblc_pkg::pblc_pins_t pins_out,
    output int                   int_count_out,
    output int                   rst_count_out
);
    // Idle pins: button released, no supply.
    initial begin
        pins_out = PINS_RST;
        int_count_out = 0;
        rst_count_out = 0;
    end

    // Each falling edge is one notification.
    always @(posedge clk_in) begin
        if ($fell(host_int_n_in)) int_count_out <= int_count_out + 1;
        if ($fell(reset_n_in)) rst_count_out <= rst_count_out + 1;
    end

    // A pause follows each change so no press overlaps a settling supply.
    task automatic set_levels(input logic bat, vin, chg, sw, flt);
        @(posedge clk_in);
        pins_out <= '{pins_out.push_button_n, sw, bat, vin, chg, flt};
        repeat (8) @(posedge clk_in);
    endtask

    // Holds the button low, then releases it.
    task automatic press(input int cycles);
        @(posedge clk_in);
        pins_out.push_button_n <= 1'b0;
        repeat (cycles) @(posedge clk_in);
        pins_out.push_button_n <= 1'b1;
        repeat (8) @(posedge clk_in);
    endtask
endmodule

/* File: verification/tb.sv */
// Testbench for the push-button and output-switch controller.
// Assumes a bound checker; the host model drives the pins.
`timescale 1ns/1ns
module tb;
    import pblc_pkg::*;
    localparam int unsigned WAKE_T [4] = '{20, 30, 40, 50};
    localparam int unsigned HOLD_T [4] = '{100, 120, 140, 160};
    logic        clk = 1'b0;
    logic        nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, sw_en, pass, pd, int_n, irq;
    logic        rst_n, rail, ship, hiz, on;
    logic [11:0] target;
    logic [4:0]  code;
    logic [4:0]  codes [4] = '{5'h00, 5'h19, 5'h1A, 5'h1F};
    pblc_pins_t  pins;
    int          ints, rsts, num_errors = 0, samples_checked = 0, cyc = 0;

    always #5 clk = ~clk;

    pblc_top #(.WAKE_CYC_P(WAKE_T), .HOLD_CYC_P(HOLD_T), .RESET_D_P(40),
        .INT_CYC_P(16)) i_dut (.CLK_IN(clk), .NRST_IN(nrst), .PINS_IN(pins),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .SWITCH_ENABLE_OUT(sw_en),
        .PASS_THROUGH_OUT(pass), .PULLDOWN_OUT(pd), .TARGET_MV_OUT(target),
        .HOST_INT_N_OUT(int_n), .IRQ_OUT(irq), .RESET_N_OUT(rst_n),
        .SYSTEM_RAIL_EN_OUT(rail), .SHIP_MODE_OUT(ship), .HIZ_MODE_OUT(hiz));
    pblc_host i_host (.clk_in(clk), .host_int_n_in(int_n),
        .reset_n_in(rst_n), .pins_out(pins), .int_count_out(ints),
        .rst_count_out(rsts));

    ////////////////////////////////////////////////////////////////////////
    // One bus transfer; two idle cycles after it let flags settle.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // Compares one result and counts it.
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic final_report;
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Ends a hang well past the expected run length.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'h0000_0054);
        chk(target, 12'h708);
        apb(1'b0, OFS_STATE, 32'h0);
        chk(rd, 32'h0000_000C);
        apb(1'b0, 8'h20, 32'h0);
        chk({rd, err}, 33'h1);
        for (int i = 0; i < 16; i++) begin
            code = codes[i / 4];
            apb(1'b1, OFS_CTRL, {25'h0, 1'b1, code, i[0]});
            i_host.set_levels(1'b0, 1'b0, 1'b0, i[1], 1'b0);
            on = i[0] | i[1];
            chk(sw_en, on);
            chk(pd, !on);
            chk(pass, on && code > 5'h19);
            chk(target, VOUT_BASE_MV + code * VOUT_STEP_MV);
        end
        i_host.set_levels(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        chk(sw_en, 1'b0);
        i_host.set_levels(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        chk(sw_en, 1'b1);
        apb(1'b1, OFS_CTRL, 32'h0000_0054);
        i_host.set_levels(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        i_host.press(60);
        chk(ints, 0);
        apb(1'b1, OFS_BTN, 32'h0000_0009);
        apb(1'b1, OFS_MASK, 32'h0000_0003);
        i_host.set_levels(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        i_host.press(WAKE_T[1] - 10);
        chk(ints, 0);
        i_host.press(WAKE_T[1] + 10);
        chk({ints[7:0], irq}, 9'h003);
        apb(1'b0, OFS_BTN, 32'h0);
        chk(rd, 32'h0000_0109);
        apb(1'b0, OFS_BTN, 32'h0);
        chk(rd, 32'h0000_0009);
        apb(1'b0, OFS_IRQ, 32'h0);
        chk(rd, 32'h0000_0001);
        apb(1'b1, OFS_IRQ, 32'h0000_0001);
        chk(irq, 1'b0);
        apb(1'b1, OFS_MASK, 32'h0);
        i_host.press(WAKE_T[1] + 10);
        apb(1'b0, OFS_IRQ, 32'h0);
        chk({rd, irq}, 33'h2);
        apb(1'b1, OFS_IRQ, 32'h0000_0001);
        apb(1'b1, OFS_MASK, 32'h0000_0003);
        i_host.press(HOLD_T[2] - 10);
        chk(rsts, 0);
        apb(1'b0, OFS_BTN, 32'h0);
        i_host.press(2 * HOLD_T[2] + 40);
        chk({rsts[7:0], ints[7:0]}, 16'h0105);
        chk({ship, rail, hiz}, 3'b100);
        apb(1'b0, OFS_BTN, 32'h0);
        chk(rd, 32'h0000_0509);
        i_host.set_levels(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        chk({ship, rail}, 2'b01);
        apb(1'b1, OFS_BTN, 32'h0000_0029);
        i_host.set_levels(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        i_host.press(HOLD_T[2] + 60);
        chk(rsts, 1);
        i_host.set_levels(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        i_host.press(HOLD_T[2] + 60);
        chk(rsts, 2);
        chk({ship, rail, hiz}, 3'b010);
        apb(1'b1, OFS_BTN, 32'h0000_0019);
        apb(1'b1, OFS_CTRL, 32'h0000_0014);
        chk(rail, 1'b0);
        i_host.set_levels(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        i_host.press(HOLD_T[2] + 60);
        chk({rsts[7:0], hiz, ship}, 10'h00E);
        chk(rail, 1'b1);
        final_report();
    end
endmodule
